// file: core/ephy_pin_top.sv
// ethernet phy pin block: reduced and gigabit receive/transmit control,
// management port, precision time base with pps and aux snapshots.
// assumes all pin inputs are asynchronous to core_clk.
//
// Contract
// - in reduced mode the receive control pin carries carrier and valid on alternate cycles.
// - transmit enable is high only while the transmit data pins hold valid data.
// - the device makes the management clock for the phy.
// - each side drives the management data line only in its own phase.
// - an aux trigger edge pushes the current time into the aux fifo unless the fifo is full.
// - without the advanced feature pps pulses on each seconds increment.
// - with the advanced feature pps follows the selected pps mode.
// - the receive control pin is rx control in gigabit mode and carrier and valid interleaved in 10/100.
// - the transmit control pin is tx control in gigabit mode and tx enable in 10/100.
// - the shared clock pin is receive clock in gigabit mode and reference in 10/100.
// - the time counter may run from an external time clock instead of core_clk.
`timescale 1ns/1ns
`default_nettype none
module ephy_pin_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // receive pins
   input wire logic shared_rx_clock_pin,
   input wire logic shared_rx_control_pin,
   input wire logic [1:0] rx_data_pins,
   // transmit pins
   input wire logic ext_reference_clock,
   output logic [1:0] tx_data_pins,
   output logic shared_tx_control_pin,
   // management pins
   output logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   // time pins
   input wire logic ext_time_clock_in,
   input wire logic aux_snapshot_trigger,
   output logic pulse_per_second_out,
   // user receive stream
   output logic [1:0] rx_dibit,
   output logic rx_dibit_valid,
   output logic carrier_sense,
   // user transmit stream
   input wire logic [1:0] tx_dibit,
   input wire logic tx_dibit_valid,
   output logic tx_dibit_ready
);
   ephy_mgmt_if mif ();

   logic [ephy_pkg::SY_W-1:0] raw;
   logic [ephy_pkg::SY_W-1:0] s1_q;
   logic [ephy_pkg::SY_W-1:0] s2_q;
   logic [ephy_pkg::SY_W-1:0] prev_q;
   logic [ephy_pkg::SY_W-1:0] rise;
   logic [4:0] ctrl_q;
   logic gig;
   logic adv;
   logic ext_sel;
   ephy_pkg::ephy_pps_mode_type pps_mode;
   logic rx_edge;
   logic tx_edge;
   logic ctl_s;
   logic parity_q;
   logic carr_q;
   logic rxv_q;
   logic [1:0] rxd_q;
   logic rxdv_q;
   logic accept;
   logic [1:0] txd_q;
   logic txen_q;
   logic tick;
   logic [30:0] inc;
   logic [30:0] ns_sum;
   logic sec_roll;
   logic [29:0] ns_q;
   logic [31:0] sec_q;
   logic sec_tick_q;
   logic pps_q;
   logic [61:0] aux_mem [0:3];
   logic [1:0] aux_wr_q;
   logic [1:0] aux_rd_q;
   logic [2:0] aux_cnt_q;
   logic aux_push;
   logic aux_pop;
   logic aux_ovf_q;
   logic start_q;
   logic rd_op_q;
   logic [4:0] phy_q;
   logic [4:0] regad_q;
   logic [15:0] wdata_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   // every pin input and foreign clock enters through two flops
   assign raw = {aux_snapshot_trigger, ext_time_clock_in, ext_reference_clock,
                 rx_data_pins, shared_rx_control_pin, shared_rx_clock_pin};

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         prev_q <= '0;
      end
      else
      begin
         s1_q <= raw;
         s2_q <= s1_q;
         prev_q <= s2_q;
      end
   end

   // per-input rising edge, taken after the second flop only
   genvar gi;
   generate
      for (gi = 0; gi < ephy_pkg::SY_W; gi++)
      begin : g_edge
         assign rise[gi] = s2_q[gi] && !prev_q[gi];
      end
   endgenerate

   // control register decode
   assign gig = ctrl_q[ephy_pkg::CB_GIG];
   assign adv = ctrl_q[ephy_pkg::CB_ADV];
   assign ext_sel = ctrl_q[ephy_pkg::CB_EXT];
   assign pps_mode = ephy_pkg::ephy_pps_mode_type'(ctrl_q[ephy_pkg::CB_PPS+:2]);

   // shared clock pin: receive clock in gigabit, reference in 10/100
   assign rx_edge = rise[ephy_pkg::SY_RXCLK];
   assign tx_edge = gig ? rise[ephy_pkg::SY_REFCLK] : rise[ephy_pkg::SY_RXCLK];
   assign ctl_s = s2_q[ephy_pkg::SY_RXCTL];

   // receive control demux, parity flips on each receive clock edge
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         parity_q <= 1'h0;
         carr_q <= 1'h0;
         rxv_q <= 1'h0;
      end
      else if (rx_edge)
      begin
         parity_q <= ~parity_q;
         if (gig)
         begin
            carr_q <= ctl_s;
            rxv_q <= ctl_s;
         end
         else if (!parity_q)
            carr_q <= ctl_s;
         else
            rxv_q <= ctl_s;
      end
   end

   // data is valid only while the control says so; gigabit has no lag
   assign accept = gig ? ctl_s : rxv_q;

   // receive dibit capture, one-cycle valid pulse per accepted dibit
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         rxd_q <= 2'h0;
         rxdv_q <= 1'h0;
      end
      else
      begin
         rxdv_q <= rx_edge && accept;
         if (rx_edge && accept)
            rxd_q <= s2_q[ephy_pkg::SY_RXD+:2];
      end
   end

   assign rx_dibit = rxd_q;
   assign rx_dibit_valid = rxdv_q;
   assign carrier_sense = carr_q;

   // transmit: enable and data change together on a transmit clock edge
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         txd_q <= 2'h0;
         txen_q <= 1'h0;
      end
      else if (tx_edge)
      begin
         txen_q <= tx_dibit_valid;
         txd_q <= tx_dibit_valid ? tx_dibit : 2'h0;
      end
   end

   // same flop serves as tx control in gigabit and tx enable in 10/100
   assign shared_tx_control_pin = txen_q;
   assign tx_data_pins = txd_q;
   assign tx_dibit_ready = tx_edge;

   // time base tick: every core cycle or each external time clock edge
   assign tick = ext_sel ? rise[ephy_pkg::SY_TCLK] : 1'h1;
   assign inc = ext_sel ? ephy_pkg::EXT_INC_NS : ephy_pkg::INT_INC_NS;
   assign ns_sum = {1'h0, ns_q} + inc;
   assign sec_roll = tick && (ns_sum >= ephy_pkg::NS_PER_SEC);

   // nanosecond and second counters
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         ns_q <= 30'h00000000;
         sec_q <= 32'h00000000;
         sec_tick_q <= 1'h0;
      end
      else
      begin
         sec_tick_q <= sec_roll;
         if (sec_roll)
         begin
            ns_q <= 30'(ns_sum - ephy_pkg::NS_PER_SEC);
            sec_q <= 32'(sec_q + 32'h00000001);
         end
         else if (tick)
            ns_q <= ns_sum[29:0];
      end
   end

   // pps output; the toggle mode trades pulse width for a visible level
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         pps_q <= 1'h0;
      else if (!adv)
         pps_q <= sec_tick_q;
      else
      begin
         unique case (pps_mode)
            ephy_pkg::PPS_PULSE: pps_q <= sec_tick_q;
            ephy_pkg::PPS_TOGGLE: pps_q <= pps_q ^ sec_tick_q;
            ephy_pkg::PPS_HALF: pps_q <= (ns_q < ephy_pkg::HALF_SEC_NS);
            ephy_pkg::PPS_OFF: pps_q <= 1'h0;
         endcase
      end
   end

   assign pulse_per_second_out = pps_q;

   // aux fifo control; a full fifo drops the snapshot and flags it
   assign aux_push = rise[ephy_pkg::SY_AUX] && (aux_cnt_q != ephy_pkg::AUX_FULL);
   assign aux_pop = reg_rd && (reg_addr == ephy_pkg::A_AUX_SEC) && (aux_cnt_q != 3'h0);

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         aux_wr_q <= 2'h0;
         aux_rd_q <= 2'h0;
         aux_cnt_q <= 3'h0;
      end
      else
      begin
         if (aux_push)
            aux_wr_q <= 2'(aux_wr_q + 2'h1);
         if (aux_pop)
            aux_rd_q <= 2'(aux_rd_q + 2'h1);
         if (aux_push && !aux_pop)
            aux_cnt_q <= 3'(aux_cnt_q + 3'h1);
         else if (aux_pop && !aux_push)
            aux_cnt_q <= 3'(aux_cnt_q - 3'h1);
      end
   end

   // snapshot storage, no reset needed for data words
   always_ff @(posedge core_clk)
   begin
      if (aux_push)
         aux_mem[aux_wr_q] <= {sec_q, ns_q};
   end

   // overflow flag: a new drop wins over a status read clearing it
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         aux_ovf_q <= 1'h0;
      else if (rise[ephy_pkg::SY_AUX] && !aux_push)
         aux_ovf_q <= 1'h1;
      else if (reg_rd && reg_addr == ephy_pkg::A_STATUS)
         aux_ovf_q <= 1'h0;
   end

   // control register
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         ctrl_q <= ephy_pkg::CTRL_RST;
      else if (reg_wr && reg_addr == ephy_pkg::A_CTRL)
         ctrl_q <= reg_wdata[4:0];
   end

   // management command; a write while busy is dropped
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         start_q <= 1'h0;
         rd_op_q <= 1'h0;
         phy_q <= 5'h00;
         regad_q <= 5'h00;
         wdata_q <= 16'h0000;
      end
      else
      begin
         start_q <= reg_wr && reg_addr == ephy_pkg::A_MDIO_CMD && !mif.busy && !start_q;
         if (reg_wr && reg_addr == ephy_pkg::A_MDIO_CMD && !mif.busy && !start_q)
         begin
            rd_op_q <= reg_wdata[ephy_pkg::MC_RD];
            phy_q <= reg_wdata[ephy_pkg::MC_PHY+:5];
            regad_q <= reg_wdata[ephy_pkg::MC_REG+:5];
            wdata_q <= reg_wdata[15:0];
         end
      end
   end

   assign mif.start = start_q;
   assign mif.rd_op = rd_op_q;
   assign mif.phy = phy_q;
   assign mif.regad = regad_q;
   assign mif.wdata = wdata_q;

   // management frame engine, drives mdc and the data line
   ephy_mgmt_engine u_mgmt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .req(mif),
      .mdc(mdc),
      .mdio_in(mdio_in),
      .mdio_out(mdio_out),
      .mdio_oe(mdio_oe)
   );

   // read mux; unmapped addresses read as zero
   always_comb
   begin
      rdata_d = 32'h00000000;
      unique case (reg_addr)
         ephy_pkg::A_CTRL: rdata_d = {27'h0000000, ctrl_q};
         ephy_pkg::A_STATUS: rdata_d = {25'h0000000, aux_ovf_q, aux_cnt_q,
                                        mif.busy, rxv_q, carr_q};
         ephy_pkg::A_MDIO_DATA: rdata_d = {16'h0000, mif.rdata};
         ephy_pkg::A_TIME_NS: rdata_d = {2'h0, ns_q};
         ephy_pkg::A_TIME_SEC: rdata_d = sec_q;
         ephy_pkg::A_AUX_NS: rdata_d = {2'h0, aux_mem[aux_rd_q][29:0]};
         ephy_pkg::A_AUX_SEC: rdata_d = aux_mem[aux_rd_q][61:30];
         default: rdata_d = 32'h00000000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         rdata_q <= 32'h00000000;
      else
         rdata_q <= reg_rd ? rdata_d : 32'h00000000;
   end

   assign reg_rdata = rdata_q;

   a_demux_parity: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !gig && $changed(carr_q) |-> $past(rx_edge) && !$past(parity_q))
      else $error("carrier changed on a valid slot");

   a_rx_accept_valid: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      rx_dibit_valid |-> $past(rx_edge) && $past(accept))
      else $error("receive data taken without valid");

   a_txen_with_data: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(txen_q) |-> $past(tx_edge) && $past(tx_dibit_valid) && txd_q == $past(tx_dibit))
      else $error("tx enable rose without data");

   a_aux_push_count: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      aux_push && !aux_pop |=> aux_cnt_q == 3'($past(aux_cnt_q) + 3'h1))
      else $error("aux snapshot not stored");

   a_pps_on_second: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !adv && sec_roll ##1 !adv |=> pps_q ##1 !pps_q || sec_tick_q)
      else $error("pps missing on seconds increment");

   a_pps_mode_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      adv && pps_mode == ephy_pkg::PPS_OFF ##1 adv && pps_mode == ephy_pkg::PPS_OFF |-> !pps_q)
      else $error("pps active in off mode");

   a_gig_rxctl_role: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      gig && rx_edge |=> carr_q == rxv_q)
      else $error("gigabit control not used as rx control");

   a_tx_clock_role: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !gig && rise[ephy_pkg::SY_RXCLK] |-> tx_dibit_ready)
      else $error("10/100 transmit not timed by shared clock pin");

   a_ext_time_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ext_sel && !rise[ephy_pkg::SY_TCLK] |=> $stable(ns_q) && $stable(sec_q))
      else $error("time advanced without external clock edge");
endmodule : ephy_pin_top
`default_nettype wire

// file: core/ephy_pkg.sv
// shared constants for the ethernet phy pin block: register map,
// field layout, management frame layout and time base figures.
// assumes a 100 MHz core clock feeding every consumer.
package ephy_pkg;
   // core clock
   localparam int CLK_PERIOD_NS = 10;
   // management clock, least period 400 ns, half period rounds up
   localparam int MDC_PERIOD_NS = 400;
   localparam int MDC_HALF_CYC = (MDC_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam logic [4:0] MDC_HALF_LAST = 5'(MDC_HALF_CYC - 1);
   // management frame: 32 preamble bits, then 32 frame bits
   localparam logic [31:0] MDF_PRE = 32'hFFFFFFFF;
   localparam logic [1:0] MDF_ST = 2'h1;
   localparam logic [1:0] MDF_OP_RD = 2'h2;
   localparam logic [1:0] MDF_OP_WR = 2'h1;
   localparam logic [1:0] MDF_TA_WR = 2'h2;
   localparam logic [5:0] MDF_TA_BIT = 6'h2E;
   localparam logic [5:0] MDF_DATA_BIT = 6'h30;
   localparam logic [5:0] MDF_LAST = 6'h3F;
   // time base
   localparam logic [30:0] NS_PER_SEC = 31'h3B9ACA00;
   localparam logic [29:0] HALF_SEC_NS = 30'h1DCD6500;
   localparam int EXT_TCLK_PERIOD_NS = 40;
   localparam logic [30:0] INT_INC_NS = 31'(CLK_PERIOD_NS);
   localparam logic [30:0] EXT_INC_NS = 31'(EXT_TCLK_PERIOD_NS);
   // register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_MDIO_CMD = 8'h08;
   localparam logic [7:0] A_MDIO_DATA = 8'h0C;
   localparam logic [7:0] A_TIME_NS = 8'h10;
   localparam logic [7:0] A_TIME_SEC = 8'h14;
   localparam logic [7:0] A_AUX_NS = 8'h18;
   localparam logic [7:0] A_AUX_SEC = 8'h1C;
   // control fields
   localparam int CB_GIG = 0;
   localparam int CB_ADV = 1;
   localparam int CB_PPS = 2;
   localparam int CB_EXT = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;
   // status fields
   localparam int SB_CARR = 0;
   localparam int SB_RXV = 1;
   localparam int SB_BUSY = 2;
   localparam int SB_CNT = 3;
   localparam int SB_OVF = 6;
   // management command fields
   localparam int MC_REG = 16;
   localparam int MC_PHY = 21;
   localparam int MC_RD = 26;
   // auxiliary snapshot fifo
   localparam logic [2:0] AUX_FULL = 3'h4;
   // synchroniser slots for pin inputs
   localparam int SY_RXCLK = 0;
   localparam int SY_RXCTL = 1;
   localparam int SY_RXD = 2;
   localparam int SY_REFCLK = 4;
   localparam int SY_TCLK = 5;
   localparam int SY_AUX = 6;
   localparam int SY_W = 7;
   // pulse-per-second modes under the advanced time feature
   typedef enum logic [1:0] {PPS_PULSE, PPS_TOGGLE, PPS_HALF, PPS_OFF} ephy_pps_mode_type;
endpackage : ephy_pkg

// file: core/ephy_mgmt_if.sv
// request and answer between register side and management engine.
// assumes both ends run on core_clk.
`timescale 1ns/1ns
`default_nettype none
interface ephy_mgmt_if;
   logic start;
   logic rd_op;
   logic [4:0] phy;
   logic [4:0] regad;
   logic [15:0] wdata;
   logic busy;
   logic [15:0] rdata;
   modport ctrl (output start, rd_op, phy, regad, wdata, input busy, rdata);
   modport engine (input start, rd_op, phy, regad, wdata, output busy, rdata);
endinterface : ephy_mgmt_if
`default_nettype wire

// file: core/ephy_mgmt_engine.sv
// management frame engine: makes mdc and runs one read or write frame.
// assumes start is only raised while busy is low.
`timescale 1ns/1ns
`default_nettype none
module ephy_mgmt_engine (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // request from the register side
   ephy_mgmt_if.engine req,
   // management pins
   output logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe
);
   logic s1_q;
   logic s2_q;
   logic mdc_q;
   logic busy_q;
   logic rd_q;
   logic [4:0] div_q;
   logic [5:0] bit_q;
   logic [63:0] sh_q;
   logic [15:0] rdat_q;
   logic wrap;

   assign wrap = busy_q && (div_q == ephy_pkg::MDC_HALF_LAST);

   // data line synchroniser, phy drives it on its own timing
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s1_q <= 1'h0;
         s2_q <= 1'h0;
      end
      else
      begin
         s1_q <= mdio_in;
         s2_q <= s1_q;
      end
   end

   // half-period divider, held at zero while idle
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || !busy_q || wrap)
         div_q <= 5'h00;
      else
         div_q <= 5'(div_q + 5'h01);
   end

   // frame shifter, bits change on the falling mdc edge
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         busy_q <= 1'h0;
         mdc_q <= 1'h0;
         rd_q <= 1'h0;
         bit_q <= 6'h00;
         sh_q <= 64'h0000000000000000;
      end
      else if (!busy_q)
      begin
         mdc_q <= 1'h0;
         if (req.start)
         begin
            busy_q <= 1'h1;
            rd_q <= req.rd_op;
            bit_q <= 6'h00;
            sh_q <= {ephy_pkg::MDF_PRE, ephy_pkg::MDF_ST,
                     req.rd_op ? ephy_pkg::MDF_OP_RD : ephy_pkg::MDF_OP_WR,
                     req.phy, req.regad, ephy_pkg::MDF_TA_WR, req.wdata};
         end
      end
      else if (wrap)
      begin
         mdc_q <= ~mdc_q;
         if (mdc_q)
         begin
            sh_q <= {sh_q[62:0], 1'h0};
            bit_q <= 6'(bit_q + 6'h01);
            if (bit_q == ephy_pkg::MDF_LAST)
               busy_q <= 1'h0;
         end
      end
   end

   // read data taken on the rising mdc edge
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         rdat_q <= 16'h0000;
      else if (wrap && !mdc_q && rd_q && bit_q >= ephy_pkg::MDF_DATA_BIT)
         rdat_q <= {rdat_q[14:0], s2_q};
   end

   // release the line from turnaround on in a read frame
   assign mdio_oe = busy_q && (!rd_q || bit_q < ephy_pkg::MDF_TA_BIT);
   assign mdio_out = sh_q[63];
   assign mdc = mdc_q;
   assign req.busy = busy_q;
   assign req.rdata = rdat_q;

   a_mdio_read_release: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      busy_q && rd_q && bit_q >= ephy_pkg::MDF_TA_BIT |-> !mdio_oe)
      else $error("device drives data line during phy phase");

   a_mdc_half_period: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(mdc_q) |-> ##20 $fell(mdc_q))
      else $error("mdc edge off the half period");
endmodule : ephy_mgmt_engine
`default_nettype wire

// file: tb/ephy_phy_model.sv
// phy stand-in: rx clock, interleaved rx control, mdio answers.
// assumes the bench raises run only after reset is released.
`timescale 1ns/1ns
`default_nettype none
module ephy_phy_model (
   // stimulus from the bench
   input wire logic run,
   input wire logic gig,
   input wire logic car,
   input wire logic dv,
   input wire logic [1:0] dat,
   input wire logic [15:0] rd_word,
   // receive pins
   output logic clk_pin,
   output logic ctl_pin,
   output logic [1:0] rxd,
   // management pins
   input wire logic mdc,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   output logic mdio_wire,
   // what the wire carried
   output logic [63:0] frame,
   output int n_rise,
   output int n_clash
);
   logic par;
   logic drv;
   logic bitv;
   logic [1:0] hist;
   int cnt;
   initial
   begin
      {clk_pin, ctl_pin, rxd, par, drv, bitv, hist} = '0;
      {n_rise, n_clash, cnt} = '0;
   end
   // reference clock, 125 ns, still until run
   always
   begin
      #63 clk_pin = run;
      #62 clk_pin = 1'b0;
   end
   // next slot: odd carries valid, even carrier; gig sends valid only
   always @(negedge clk_pin)
   begin
      ctl_pin <= gig || !par ? dv : car;
      rxd <= dv || hist != 2'h0 ? dat : ~dat; // data outlives valid, demux lags
      hist <= {hist[0], dv};
      par <= ~par;
   end
   // the enabled side drives, else the pull-up wins
   assign mdio_wire = mdio_oe ? mdio_out : (drv ? bitv : 1'b1);
   // sample on mdc rise, answer reads after the turnaround
   always @(posedge mdc)
   begin
      frame <= {frame[62:0], mdio_wire};
      n_rise <= n_rise + 1;
      n_clash <= n_clash + int'(mdio_oe && drv);
      drv <= !mdio_oe && cnt < 17;
      bitv <= cnt == 0 ? 1'b0 : rd_word[4'(16 - cnt)];
      cnt <= mdio_oe ? 0 : cnt + 1;
   end
endmodule : ephy_phy_model
`default_nettype wire

// file: tb/tb.sv
// bench for the phy pin block: phy model, register tasks, stream checks.
// assumes register reads answer one cycle after the strobe.
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rv, seed = 32'h7392;
   logic rxc, rxctl, mdc, mdo, moe, mdw, txctl, rxv, crs, pps, tx_rdy;
   logic ref_clk = 1'b0, tclk = 1'b0, aux = 1'b0, tx_valid = 1'b0, tx_due = 1'b0;
   logic run = 1'b0, gig = 1'b0, car = 1'b0, dv = 1'b0;
   logic [1:0] rxd, txd, rxo, dat = 2'h2, tx_dibit = 2'h0;
   logic [2:0] tx_exp = 3'h0;
   logic [15:0] rd_word = 16'h0, wd;
   logic [63:0] frame;
   logic [7:0] ra [3] = '{8'h00, 8'h04, 8'h2C};
   int n_rise, n_clash, r0, t0, n_acc, n_dv, n_mismatch = 0, n_checks = 0;
   ephy_pin_top u_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .shared_rx_clock_pin(rxc), .shared_rx_control_pin(rxctl),
      .rx_data_pins(rxd), .ext_reference_clock(ref_clk), .tx_data_pins(txd),
      .shared_tx_control_pin(txctl), .mdc, .mdio_in(mdw), .mdio_out(mdo), .mdio_oe(moe),
      .ext_time_clock_in(tclk), .aux_snapshot_trigger(aux), .pulse_per_second_out(pps),
      .rx_dibit(rxo), .rx_dibit_valid(rxv), .carrier_sense(crs), .tx_dibit,
      .tx_dibit_valid(tx_valid), .tx_dibit_ready(tx_rdy));
   ephy_phy_model u_phy (.run, .gig, .car, .dv, .dat, .rd_word, .clk_pin(rxc),
      .ctl_pin(rxctl), .rxd, .mdc, .mdio_out(mdo), .mdio_oe(moe), .mdio_wire(mdw),
      .frame, .n_rise, .n_clash);
   // core 10 ns, time clock 40 ns, transmit reference 125 ns
   always #5 core_clk = ~core_clk;
   always #20 tclk = ~tclk;
   always
   begin
      #63 ref_clk = 1'b1;
      #62 ref_clk = 1'b0;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [63:0] s, input logic [63:0] e, input string w);
      n_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", w, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge core_clk);
   endtask : rd
   task automatic mgmt(input logic rdop);
      logic [63:0] ef;
      wd = seed[15:0];
      r0 = n_rise;
      wr(ephy_pkg::A_MDIO_CMD, {5'h0, rdop, 10'h0BA, wd});
      repeat (3) @(posedge core_clk);
      rv = 32'h4;
      for (int i = 0; i < 2000 && rv[ephy_pkg::SB_BUSY]; i++) rd(ephy_pkg::A_STATUS);
      chk(rv[ephy_pkg::SB_BUSY], 1'b0, "busy");
      ef = {ephy_pkg::MDF_PRE, ephy_pkg::MDF_ST, rdop ? ephy_pkg::MDF_OP_RD :
         ephy_pkg::MDF_OP_WR, 10'h0BA, ephy_pkg::MDF_TA_WR, rdop ? rd_word : wd};
      chk(frame, ef, "frame");
      chk(n_rise - r0, 64, "mdc rises");
   endtask : mgmt
   task automatic pulse_aux;
      aux <= 1'b1;
      repeat (6) @(posedge core_clk);
      aux <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask : pulse_aux
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   // random transmit dibits, each held until taken
   always @(posedge core_clk)
      if (tx_rdy === 1'b1 || !tx_valid)
      begin
         seed <= lfsr(seed);
         tx_valid <= seed[3] & rst_n;
         tx_dibit <= seed[1:0];
      end
   // pins follow the dibit taken one cycle earlier
   always @(posedge core_clk)
   begin
      if (tx_due) chk({txctl, txd}, tx_exp, "tx pins");
      tx_due <= tx_rdy === 1'b1;
      tx_exp <= tx_valid ? {1'b1, tx_dibit} : 3'h0;
   end
   // every accepted dibit carries the phy's valid value; gig edges counted
   always @(posedge core_clk)
      if (rxv === 1'b1)
      begin
         n_acc++;
         chk(rxo, dat, "rx dibit");
      end
   always @(posedge rxc) if (gig && rxctl) n_dv++;
   initial
   begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      foreach (ra[i])
      begin
         rd(ra[i]);
         chk(rv, 0, "reset read");
      end
      // 10/100: carrier, then valid dibits, on one interleaved pin
      run <= 1'b1;
      car <= 1'b1;
      repeat (150) @(posedge core_clk);
      chk(crs, 1'b1, "carrier");
      rd(ephy_pkg::A_STATUS);
      chk(rv[ephy_pkg::SB_CARR], 1'b1, "status carrier");
      dv <= 1'b1;
      repeat (300) @(posedge core_clk);
      chk(n_acc > 15, 1'b1, "dibits taken");
      dv <= 1'b0;
      car <= 1'b0;
      repeat (150) @(posedge core_clk);
      chk(crs, 1'b0, "carrier idle");
      $display("done rx 10/100");
      // gig: control pin is valid and carrier at once
      wr(ephy_pkg::A_CTRL, 32'h1);
      gig <= 1'b1;
      dat <= 2'h1;
      repeat (50) @(posedge core_clk);
      n_acc = 0;
      n_dv = 0;
      repeat (40)
      begin
         dv <= seed[5];
         repeat (13) @(posedge core_clk);
      end
      dv <= 1'b1;
      repeat (60) @(posedge core_clk);
      chk(crs, 1'b1, "gig carrier");
      dv <= 1'b0;
      repeat (60) @(posedge core_clk);
      chk(n_acc, n_dv, "gig dibits");
      $display("done rx gig");
      mgmt(1'b0);
      rd_word = seed[31:16];
      mgmt(1'b1);
      rd(ephy_pkg::A_MDIO_DATA);
      chk(rv, {16'h0, rd_word}, "read word");
      chk(n_clash, 0, "drive clash");
      chk(mdc, 1'b0, "mdc idle");
      $display("done mgmt");
      // time base from core clock, then from the external time clock
      wr(ephy_pkg::A_CTRL, 32'h0);
      rd(ephy_pkg::A_TIME_NS);
      t0 = rv;
      rd(ephy_pkg::A_TIME_NS);
      chk(rv - t0, 20, "ns step");
      wr(ephy_pkg::A_CTRL, 32'h10);
      rd(ephy_pkg::A_TIME_NS);
      t0 = rv;
      repeat (98) @(posedge core_clk);
      rd(ephy_pkg::A_TIME_NS);
      chk((rv - t0) inside {[960:1080]}, 1'b1, "ext ns");
      // aux stamp near the trigger, then overflow, clear and pop
      wr(ephy_pkg::A_CTRL, 32'h0);
      rd(ephy_pkg::A_TIME_NS);
      t0 = rv;
      pulse_aux();
      rd(ephy_pkg::A_AUX_NS);
      chk((rv - t0) inside {[20:120]}, 1'b1, "aux stamp");
      repeat (5) pulse_aux();
      rd(ephy_pkg::A_STATUS);
      chk(rv[6:3], {1'b1, ephy_pkg::AUX_FULL}, "aux full");
      rd(ephy_pkg::A_STATUS);
      chk(rv[6:3], {1'b0, ephy_pkg::AUX_FULL}, "ovf clear");
      rd(ephy_pkg::A_AUX_SEC);
      rd(ephy_pkg::A_STATUS);
      chk(rv[5:3], 3'h3, "aux pop");
      $display("done time");
      // well inside the first half second: only half mode is high
      for (int m = 0; m < 4; m++)
      begin
         wr(ephy_pkg::A_CTRL, 32'(m * 4 + 2));
         repeat (4) @(posedge core_clk);
         chk(pps, m == ephy_pkg::PPS_HALF, "pps mode");
      end
      wr(ephy_pkg::A_CTRL, 32'h8);
      repeat (4) @(posedge core_clk);
      chk(pps, 1'b0, "pps plain");
      $display("done pps");
      give_verdict();
   end
   // cut a hang short well past the expected run length
   initial
   begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
endmodule : tb
`default_nettype wire
